// ---- wrag_addr_gen.sv ----
// Purpose: forms register file addresses for direct and working register modes
// Assumes: decoder request and pointer writes synchronous to clk_i
// Notes: one registered stage; set2 always low from this block
//
// Contract
// - direct mode reaches all but set 2
// - pair starts on even address
// - msb even byte, lsb odd byte
// - reset pointers select c0-c7 and c8-cf
// - common area works on every page
// - 4-bit msb chooses the pointer
// - pointer upper five bits form slice
// - instruction low three bits pick register
// - 01110b with 110b gives 76h
// - upper nibble 1100b means working form
// - bit 3 selects pointer in 8-bit form
// - 10101b with 011 gives abh
// - pointers loadable at d6h and d7h
// - pointers never reach set 2
module wrag_addr_gen (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire wrag_pkg::wrag_req_t req_i,
    input wire wrag_pkg::wrag_wr_t wr_i,
    output wrag_pkg::wrag_rsp_t rsp_o,
    output logic [7:0] ptr_low_o,
    output logic [7:0] ptr_high_o
);
    // ==========================================
    // slice pointers
    logic [7:0] slice_pointer_low_q;
    logic [7:0] slice_pointer_high_q;
    wrag_pkg::wrag_rsp_t rsp_q, rsp_d;

    wire wr_low = wr_i.en && (wr_i.addr == wrag_pkg::PTR_LOW_ADDR);
    wire wr_high = wr_i.en && (wr_i.addr == wrag_pkg::PTR_HIGH_ADDR);

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            slice_pointer_low_q <= wrag_pkg::PTR_LOW_RST;
            slice_pointer_high_q <= wrag_pkg::PTR_HIGH_RST;
        end else begin
            if (wr_low) begin
                slice_pointer_low_q <= wr_i.data;
            end
            if (wr_high) begin
                slice_pointer_high_q <= wr_i.data;
            end
        end
    end

    // ==========================================
    // address composition
    function automatic logic [7:0] work_addr(input logic [3:0] nib,
                                             input logic [7:0] p0,
                                             input logic [7:0] p1);
        logic [7:0] p;
        p = nib[wrag_pkg::SEL_BIT] ? p1 : p0;
        // slice bits from pointer, index bits from instruction
        work_addr = {p[wrag_pkg::SLICE_HI:wrag_pkg::SLICE_LO],
                     nib[wrag_pkg::IDX_HI:0]};
    endfunction

    wire [3:0] low_nib = req_i.addr[3:0];
    wire is_w8 = (req_i.mode == wrag_pkg::MODE_WORK8)
              || (req_i.mode == wrag_pkg::MODE_DIRECT
                  && req_i.addr[7:4] == wrag_pkg::WORK_PREFIX);
    wire is_w4 = (req_i.mode == wrag_pkg::MODE_WORK4);
    wire is_dir = (req_i.mode == wrag_pkg::MODE_DIRECT) && !is_w8;
    wire [7:0] w_addr = work_addr(low_nib, slice_pointer_low_q, slice_pointer_high_q);
    // raw direct address; working forms override it
    wire [7:0] base = (is_w4 || is_w8) ? w_addr : req_i.addr;
    // pairs forced even so the msb byte lands on the even register
    wire [7:0] even = req_i.pair ? {base[7:1], 1'b0} : base;
    wire [7:0] odd = {even[7:1], 1'b1};
    // a direct address in the common area is taken as 8-bit working form, so dir_common never rises
    wire dir_common = is_dir && (req_i.addr[7:4] == wrag_pkg::COMMON_NIB);

    always_comb begin
        rsp_d = '0;
        rsp_d.valid = req_i.valid && (req_i.mode != wrag_pkg::MODE_NONE);
        rsp_d.addr = even;
        rsp_d.addr_lsb = req_i.pair ? odd : even;
        // neither direct nor working forms ever select set 2
        rsp_d.set2 = 1'b0;
        rsp_d.invalid = req_i.valid && dir_common;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    assign rsp_o = rsp_q;
    assign ptr_low_o = slice_pointer_low_q;
    assign ptr_high_o = slice_pointer_high_q;

    // ==========================================
    // checks
    sequence s_w4_low;
        req_i.valid && is_w4 && !low_nib[3] && !req_i.pair;
    endsequence

    sequence s_w4_high;
        req_i.valid && is_w4 && low_nib[3] && !req_i.pair;
    endsequence

    sequence s_w8_low;
        req_i.valid && is_w8 && !low_nib[3] && !req_i.pair;
    endsequence

    sequence s_w8_high;
        req_i.valid && is_w8 && low_nib[3] && !req_i.pair;
    endsequence

    sequence s_w8_prefix;
        req_i.valid && req_i.mode == wrag_pkg::MODE_DIRECT && req_i.addr[7:4] == wrag_pkg::WORK_PREFIX;
    endsequence

    sequence s_none;
        req_i.valid && req_i.mode == wrag_pkg::MODE_NONE;
    endsequence

    sequence s_idle;
        !req_i.valid;
    endsequence

    sequence s_single;
        req_i.valid && !req_i.pair;
    endsequence

    sequence s_pair;
        req_i.valid && req_i.pair;
    endsequence

    sequence s_work;
        req_i.valid && (is_w4 || is_w8) && !req_i.pair;
    endsequence

    sequence s_work_pair;
        req_i.valid && (is_w4 || is_w8) && req_i.pair;
    endsequence

    sequence s_wr_quiet_low;
        !wr_low;
    endsequence

    sequence s_wr_quiet_high;
        !wr_high;
    endsequence

    a_reset_ptr_low: assert property (@(posedge clk_i)
        !rstn_i |=> slice_pointer_low_q == wrag_pkg::PTR_LOW_RST)
        else $error("low pointer reset value wrong");
    a_reset_ptr_high: assert property (@(posedge clk_i)
        !rstn_i |=> slice_pointer_high_q == wrag_pkg::PTR_HIGH_RST)
        else $error("high pointer reset value wrong");
    a_w4_low_ptr: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_w4_low |=> rsp_o.addr == {$past(slice_pointer_low_q[7:3]), $past(low_nib[2:0])})
        else $error("4-bit address not from low pointer");
    a_w8_high_ptr: assert property (@(posedge clk_i) disable iff (!rstn_i)
        req_i.valid && is_w8 && low_nib[3] && !req_i.pair
        |=> rsp_o.addr == {$past(slice_pointer_high_q[7:3]), $past(low_nib[2:0])})
        else $error("8-bit address not from high pointer");
    a_pair_even: assert property (@(posedge clk_i) disable iff (!rstn_i)
        req_i.valid && req_i.pair |=> !rsp_o.addr[0] && rsp_o.addr_lsb == rsp_o.addr + 8'h01)
        else $error("pair not even then odd");
    a_ptr_load: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_low |=> slice_pointer_low_q == $past(wr_i.data))
        else $error("low pointer not loaded");
    a_no_set2: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !rsp_o.set2)
        else $error("set 2 selected");
    a_direct_pass: assert property (@(posedge clk_i) disable iff (!rstn_i)
        req_i.valid && is_dir && !req_i.pair |=> rsp_o.addr == $past(req_i.addr))
        else $error("direct address altered");

    // ==========================================
    // pointer selection and slice forming
    a_w4_high_ptr: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_w4_high |=> rsp_o.addr == {$past(slice_pointer_high_q[7:3]), $past(low_nib[2:0])})
        else $error("4-bit address not from high pointer");

    a_w8_low_ptr: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_w8_low |=> rsp_o.addr == {$past(slice_pointer_low_q[7:3]), $past(low_nib[2:0])})
        else $error("8-bit address not from low pointer");

    a_w8_slice: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_w8_high |=> rsp_o.addr[7:3] == $past(slice_pointer_high_q[7:3]))
        else $error("8-bit slice bits wrong");

    a_w4_slice: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_w4_low |=> rsp_o.addr[7:3] == $past(slice_pointer_low_q[7:3]))
        else $error("4-bit slice bits wrong");

    a_work_index: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_work |=> rsp_o.addr[2:0] == $past(low_nib[2:0]))
        else $error("working index bits wrong");

    a_prefix_work: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_w8_prefix |=> !rsp_o.invalid)
        else $error("prefix address flagged invalid");

    a_prefix_high: assert property (@(posedge clk_i) disable iff (!rstn_i)
        req_i.valid && req_i.mode == wrag_pkg::MODE_DIRECT && req_i.addr[7:4] == 4'hC
        && low_nib[3] && !req_i.pair
        |=> rsp_o.addr == {$past(slice_pointer_high_q[7:3]), $past(low_nib[2:0])})
        else $error("prefix address not working form");

    a_w8_explicit: assert property (@(posedge clk_i) disable iff (!rstn_i)
        req_i.valid && req_i.mode == wrag_pkg::MODE_WORK8 && !req_i.pair
        |=> rsp_o.addr[2:0] == $past(low_nib[2:0]))
        else $error("explicit 8-bit form index wrong");

    a_example_76: assert property (@(posedge clk_i) disable iff (!rstn_i)
        req_i.valid && is_w4 && low_nib == 4'h6 && slice_pointer_low_q[7:3] == 5'h0e
        && !req_i.pair |=> rsp_o.addr == 8'h76)
        else $error("4-bit example address wrong");

    a_example_ab: assert property (@(posedge clk_i) disable iff (!rstn_i)
        req_i.valid && is_w8 && low_nib == 4'hb && slice_pointer_high_q[7:3] == 5'h15
        && !req_i.pair |=> rsp_o.addr == 8'hab)
        else $error("8-bit example address wrong");

    a_common_low: assert property (@(posedge clk_i) disable iff (!rstn_i)
        req_i.valid && is_w4 && !low_nib[3] && slice_pointer_low_q == wrag_pkg::PTR_LOW_RST
        |=> rsp_o.addr[7:4] == wrag_pkg::COMMON_NIB)
        else $error("low slice left common area");

    a_common_high: assert property (@(posedge clk_i) disable iff (!rstn_i)
        req_i.valid && is_w4 && low_nib[3] && slice_pointer_high_q == wrag_pkg::PTR_HIGH_RST
        |=> rsp_o.addr[7:4] == wrag_pkg::COMMON_NIB)
        else $error("high slice left common area");

    // ==========================================
    // answer framing and pairs
    a_none_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_none |=> !rsp_o.valid)
        else $error("refused mode answered");

    a_idle_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_idle |=> !rsp_o.valid && !rsp_o.invalid)
        else $error("answer without request");

    a_valid_follow: assert property (@(posedge clk_i) disable iff (!rstn_i)
        req_i.valid && req_i.mode != wrag_pkg::MODE_NONE |=> rsp_o.valid)
        else $error("request not answered");

    a_valid_cause: assert property (@(posedge clk_i) disable iff (!rstn_i)
        rsp_o.valid |-> $past(req_i.valid))
        else $error("answer has no cause");

    a_reset_rsp: assert property (@(posedge clk_i)
        !rstn_i |=> rsp_o == '0)
        else $error("answer not cleared by reset");

    a_single_lsb: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_single |=> rsp_o.addr_lsb == rsp_o.addr)
        else $error("single access lsb address differs");

    a_pair_lsb_odd: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_pair |=> rsp_o.addr_lsb[0])
        else $error("pair lsb byte not odd");

    a_pair_lsb_next: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_pair |=> rsp_o.addr_lsb == {rsp_o.addr[7:1], 1'b1})
        else $error("pair lsb byte not next");

    a_pair_same_word: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_pair |=> rsp_o.addr[7:1] == rsp_o.addr_lsb[7:1])
        else $error("pair bytes split");

    a_work_pair_even: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_work_pair |=> !rsp_o.addr[0])
        else $error("working pair not even");

    a_direct_pair: assert property (@(posedge clk_i) disable iff (!rstn_i)
        req_i.valid && is_dir && req_i.pair |=> rsp_o.addr[7:1] == $past(req_i.addr[7:1]))
        else $error("direct pair address altered");

    a_dir_valid: assert property (@(posedge clk_i) disable iff (!rstn_i)
        req_i.valid && is_dir |=> rsp_o.valid && !rsp_o.set2)
        else $error("direct access not delivered");

    a_invalid_valid: assert property (@(posedge clk_i) disable iff (!rstn_i)
        rsp_o.invalid |-> rsp_o.valid)
        else $error("invalid flag without answer");

    a_work_no_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_work |=> !rsp_o.invalid)
        else $error("working access flagged invalid");

    // ==========================================
    // pointer loading
    a_ptr_high_load: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_high |=> slice_pointer_high_q == $past(wr_i.data))
        else $error("high pointer not loaded");

    a_ptr_low_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_wr_quiet_low |=> $stable(slice_pointer_low_q))
        else $error("low pointer changed unasked");

    a_ptr_high_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_wr_quiet_high |=> $stable(slice_pointer_high_q))
        else $error("high pointer changed unasked");
endmodule

// ---- wrag_addr_gen_bench.sv ----
// Purpose: self-checking bench for the address generator
// Assumes: one cycle answer latency, pointer writes on wr_i
// Notes: requests drive 1 ns after the rising edge
module wrag_addr_gen_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    wrag_pkg::wrag_req_t req_i = '0;
    wrag_pkg::wrag_wr_t wr_i = '0;
    wrag_pkg::wrag_rsp_t rsp_o;
    logic [7:0] ptr_low_o;
    logic [7:0] ptr_high_o;
    logic [7:0] hits;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    wrag_addr_gen u_wrag_addr_gen (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i), .wr_i(wr_i),
        .rsp_o(rsp_o), .ptr_low_o(ptr_low_o), .ptr_high_o(ptr_high_o));
    wrag_rf_model u_wrag_rf_model (.clk_i(clk_i), .rsp_i(rsp_o), .hits_o(hits));
    // ==========================================
    // clock and hang guard
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            finish_test();
        end
    end
    // ==========================================
    // shared tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1 wr_i = '{en: 1'b1, addr: a, data: d};
        @(posedge clk_i);
        #1 wr_i.en = 1'b0;
    endtask
    // answer is left standing on rsp_o when this returns
    task automatic req(input wrag_pkg::wrag_mode_t m, input logic [7:0] a, input logic p);
        @(posedge clk_i);
        #1 req_i = '{valid: 1'b1, mode: m, addr: a, pair: p};
        @(posedge clk_i);
        #1 req_i.valid = 1'b0;
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset();
        chk(ptr_low_o, 8'hC0);
        chk(ptr_high_o, 8'hC8);
        req(wrag_pkg::MODE_WORK4, 8'h05, 1'b0);
        chk(rsp_o.addr, 8'hC5);
        req(wrag_pkg::MODE_WORK4, 8'h0F, 1'b0);
        chk(rsp_o.addr, 8'hCF);
        $display("test reset done");
    endtask
    task automatic t_work4();
        wr(8'hD6, 8'h70);
        chk(ptr_low_o, 8'h70);
        req(wrag_pkg::MODE_WORK4, 8'h06, 1'b0);
        chk(rsp_o.addr, 8'h76);
        chk({7'h00, rsp_o.set2}, 8'h00);
        $display("test work4 done");
    endtask
    task automatic t_work8();
        wr(8'hD7, 8'hA8);
        chk(ptr_high_o, 8'hA8);
        req(wrag_pkg::MODE_WORK8, 8'hCB, 1'b0);
        chk(rsp_o.addr, 8'hAB);
        req(wrag_pkg::MODE_DIRECT, 8'hCB, 1'b0);
        chk(rsp_o.addr, 8'hAB);
        chk({7'h00, rsp_o.invalid}, 8'h00);
        req(wrag_pkg::MODE_DIRECT, 8'hC3, 1'b0);
        chk(rsp_o.addr, 8'h73);
        $display("test work8 done");
    endtask
    task automatic t_pair();
        req(wrag_pkg::MODE_DIRECT, 8'h45, 1'b1);
        chk({7'h00, rsp_o.valid}, 8'h01);
        chk(rsp_o.addr, 8'h44);
        chk(rsp_o.addr_lsb, 8'h45);
        req(wrag_pkg::MODE_DIRECT, 8'h3A, 1'b0);
        chk(rsp_o.addr, 8'h3A);
        $display("test pair done");
    endtask
    task automatic t_none();
        req(wrag_pkg::MODE_NONE, 8'h12, 1'b0);
        chk({7'h00, rsp_o.valid}, 8'h00);
        chk(hits, 8'h08);
        $display("test none done");
    endtask
    task automatic finish_test();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        #1 rstn_i = 1'b1;
        t_reset();
        t_work4();
        t_work8();
        t_pair();
        t_none();
        finish_test();
    end
endmodule

// ---- wrag_pkg.sv ----
// Purpose: constants and carrier types for the working register address generator
// Assumes: 8-bit register file addresses, two slice pointers
// Notes: pointer reset values select the common area
package wrag_pkg;
    // ==========================================
    // widths and fields
    localparam int ADDR_W = 8;
    localparam int SLICE_HI = 7;
    localparam int SLICE_LO = 3;
    localparam int SEL_BIT = 3;
    localparam int IDX_HI = 2;
    // ==========================================
    // fixed addresses
    localparam logic [7:0] PTR_LOW_RST = 8'hC0;
    localparam logic [7:0] PTR_HIGH_RST = 8'hC8;
    localparam logic [7:0] PTR_LOW_ADDR = 8'hD6;
    localparam logic [7:0] PTR_HIGH_ADDR = 8'hD7;
    localparam logic [3:0] WORK_PREFIX = 4'hC;
    localparam logic [1:0] SET_UPPER = 2'h3;
    localparam logic [3:0] COMMON_NIB = 4'hC;

    typedef enum logic [1:0] {
        MODE_DIRECT = 2'b00,
        MODE_WORK4 = 2'b01,
        MODE_WORK8 = 2'b10,
        MODE_NONE = 2'b11
    } wrag_mode_t;

    // request from the decoder
    typedef struct packed {
        logic valid;
        wrag_mode_t mode;
        logic [7:0] addr;
        logic pair;
    } wrag_req_t;

    // request to the register file
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] addr_lsb;
        logic set2;
        logic invalid;
    } wrag_rsp_t;

    // pointer write port
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } wrag_wr_t;
endpackage

// ---- wrag_rf_model.sv ----
// Purpose: register file side of the address generator
// Assumes: one access per valid response cycle
// Notes: contents not modelled, only accesses counted
module wrag_rf_model (
    input wire logic clk_i,
    input wire wrag_pkg::wrag_rsp_t rsp_i,
    output logic [7:0] hits_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial hits_o = 8'h00;
    // ==========================================
    // access counter; cheap check that no answer is lost
    always @(posedge clk_i) begin
        if (rsp_i.valid === 1'b1) begin
            hits_o <= hits_o + 8'h01;
        end
    end
endmodule
